// ==== verilog/irap_pkg.sv ====
// Constants for the indirect RAM access port: register map, fields, resets.
// Assumes a 32-bit AXI4-Lite register bus and one device clock.
`default_nettype none
package irap_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] IRAP_OFF_TARGET = 8'h24;
  localparam logic [7:0] IRAP_OFF_CMD = 8'h28;
  localparam logic [7:0] IRAP_OFF_ADDR = 8'h2c;
  localparam logic [7:0] IRAP_OFF_DATA = 8'h30;
  // ==========================================================
  // Field layout
  localparam int IRAP_READY_BIT = 31;
  localparam int IRAP_TARGET_W = 4;
  localparam int IRAP_WADDR_W = 14;
  localparam int IRAP_CMD_BIT = 0;
  // ==========================================================
  // Reset values
  localparam logic [3:0] IRAP_TARGET_RST = 4'h0;
  localparam logic [13:0] IRAP_WADDR_RST = 14'h0000;
  localparam logic [31:0] IRAP_DATA_RST = 32'h0000_0000;
  localparam logic IRAP_CMD_RST = 1'b0;
  localparam logic IRAP_READY_RST = 1'b1;
  // ==========================================================
  // Target codes
  localparam logic [3:0] IRAP_TGT_RX_BUF = 4'h0;
  localparam logic [3:0] IRAP_TGT_VLAN_HASH = 4'h1;
  localparam logic [3:0] IRAP_TGT_SEG_HDR = 4'h2;
  localparam logic [3:0] IRAP_TGT_FIFO_RX = 4'h3;
  localparam logic [3:0] IRAP_TGT_FIFO_TX = 4'h4;
  localparam logic [3:0] IRAP_TGT_DESC = 4'h5;
  localparam logic [3:0] IRAP_TGT_TX_BUF = 4'h7;
  localparam logic [3:0] IRAP_TGT_RSVD = 4'h6;
  localparam int IRAP_NUM_RAMS = 8;
  // ==========================================================
  // AXI responses and sequencer states
  localparam logic [1:0] IRAP_RESP_OKAY = 2'b00;
  localparam logic [1:0] IRAP_RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    IRAP_IDLE = 2'b00,
    IRAP_REQ = 2'b01,
    IRAP_WAIT = 2'b10
  } irap_state_t;
endpackage
`default_nettype wire

// ==== verilog/irap_top.sv ====
// Indirect RAM access port: four AXI4-Lite registers drive one access to a
// selected internal RAM over a req/ack handshake.
// Assumes each RAM answers ram_ack (one-cycle) for the selected target, same clock.
// Contract
// - Ready flag in bit 31 of the selector reads low while an access runs, high after; resets to one.
// - On a read of a non-reserved target the ready flag returns high only once the fetched word sits in the data register.
// - Each access goes to the RAM named by the 4-bit target field in bits 3:0, reset zero.
// - A write to bit 0 of the command register while idle starts an access, one writes and zero reads.
// - The RAM word address comes from the 14-bit field in bits 13:0 of the address register.
// - The data register supplies write data and receives read data; resets to zero.
`default_nettype none
module irap_top
  import irap_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [irap_pkg::IRAP_NUM_RAMS-1:0] ram_req,
  output logic ram_we,
  output logic [irap_pkg::IRAP_WADDR_W-1:0] ram_addr,
  output logic [31:0] ram_wdata,
  input wire logic [irap_pkg::IRAP_NUM_RAMS-1:0] ram_ack,
  input wire logic [31:0] ram_rdata
);
  import irap_pkg::*;

  // ==========================================================
  // Register state
  logic [IRAP_TARGET_W-1:0] target_reg;
  logic cmd_reg;
  logic [IRAP_WADDR_W-1:0] waddr_reg;
  logic [31:0] data_reg;
  logic port_ready_flag_reg;
  irap_state_t state_reg;

  // ==========================================================
  // AXI write channel: address and data latched independently
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic [7:0] wr_off;
  logic [31:0] wmask;
  logic wr_hit;

  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_off = 8'(aw_addr_reg);
  assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}},
                  {8{w_strb_reg[0]}}};
  assign wr_hit = (wr_off == IRAP_OFF_TARGET) || (wr_off == IRAP_OFF_CMD) ||
                  (wr_off == IRAP_OFF_ADDR) || (wr_off == IRAP_OFF_DATA);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      s_axi_awready <= 1'b0;
    end else if (clk_en) begin
      s_axi_awready <= 1'b0;
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end else if (s_axi_awvalid && !aw_held_reg && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      s_axi_wready <= 1'b0;
    end else if (clk_en) begin
      s_axi_wready <= 1'b0;
      if (wr_fire) begin
        w_held_reg <= 1'b0;
      end else if (s_axi_wvalid && !w_held_reg && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= IRAP_RESP_OKAY;
    end else if (clk_en) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? IRAP_RESP_OKAY : IRAP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Software registers
  logic launch;
  assign launch = wr_fire && (wr_off == IRAP_OFF_CMD) && w_strb_reg[0];

  // Selector target field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      target_reg <= IRAP_TARGET_RST;
    end else if (clk_en && wr_fire && wr_off == IRAP_OFF_TARGET) begin
      // Reserved bits are simply not stored, so they read zero
      target_reg <= (target_reg & ~wmask[IRAP_TARGET_W-1:0]) |
                    (w_data_reg[IRAP_TARGET_W-1:0] & wmask[IRAP_TARGET_W-1:0]);
    end
  end

  // Command bit: kept for readback; a write while busy is stored but starts nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_reg <= IRAP_CMD_RST;
    end else if (clk_en && launch) begin
      cmd_reg <= w_data_reg[IRAP_CMD_BIT];
    end
  end

  // RAM word address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waddr_reg <= IRAP_WADDR_RST;
    end else if (clk_en && wr_fire && wr_off == IRAP_OFF_ADDR) begin
      waddr_reg <= (waddr_reg & ~wmask[IRAP_WADDR_W-1:0]) |
                   (w_data_reg[IRAP_WADDR_W-1:0] & wmask[IRAP_WADDR_W-1:0]);
    end
  end

  // Data register: software writes, and read results land here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_reg <= IRAP_DATA_RST;
    end else if (clk_en) begin
      if (state_reg == IRAP_WAIT && !ram_we && ram_ack[target_reg[2:0]]) begin
        data_reg <= ram_rdata;
      end else if (wr_fire && wr_off == IRAP_OFF_DATA) begin
        data_reg <= (data_reg & ~wmask) | (w_data_reg & wmask);
      end
    end
  end

  // ==========================================================
  // Access sequencer
  // Reserved targets would hang forever, so they complete at once with no RAM touched
  logic tgt_valid;
  logic [2:0] tgt_idx;
  assign tgt_valid = !target_reg[3] && (target_reg != IRAP_TGT_RSVD);
  assign tgt_idx = target_reg[2:0];

  // Sequencer state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= IRAP_IDLE;
    end else if (clk_en) begin
      case (state_reg)
        IRAP_IDLE: begin
          if (launch) begin
            state_reg <= IRAP_REQ;
          end
        end
        IRAP_REQ: begin
          state_reg <= tgt_valid ? IRAP_WAIT : IRAP_IDLE;
        end
        IRAP_WAIT: begin
          if (ram_ack[tgt_idx]) begin
            state_reg <= IRAP_IDLE;
          end
        end
        default: begin
          state_reg <= IRAP_IDLE;
        end
      endcase
    end
  end

  // Ready flag falls at launch and rises at the ack edge, the same edge on which
  // a read word lands in the data register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_ready_flag_reg <= IRAP_READY_RST;
    end else if (clk_en) begin
      case (state_reg)
        IRAP_IDLE: begin
          if (launch) begin
            port_ready_flag_reg <= 1'b0;
          end
        end
        IRAP_REQ: begin
          if (!tgt_valid) begin
            port_ready_flag_reg <= 1'b1;
          end
        end
        IRAP_WAIT: begin
          if (ram_ack[tgt_idx]) begin
            port_ready_flag_reg <= 1'b1;
          end
        end
        default: begin
          port_ready_flag_reg <= 1'b1;
        end
      endcase
    end
  end

  // Payload is captured once at launch and held until the ack, so a late address,
  // data or command write cannot tear an access in flight; the target field is not captured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ram_we <= 1'b0;
      ram_addr <= '0;
      ram_wdata <= '0;
    end else if (clk_en && state_reg == IRAP_IDLE && launch) begin
      ram_we <= w_data_reg[IRAP_CMD_BIT];
      ram_addr <= waddr_reg;
      ram_wdata <= data_reg;
    end
  end

  // One-hot request, raised one cycle after launch and dropped on the ack
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ram_req <= '0;
    end else if (clk_en) begin
      case (state_reg)
        IRAP_REQ: begin
          if (tgt_valid) begin
            ram_req <= IRAP_NUM_RAMS'(1) << tgt_idx;
          end
        end
        IRAP_WAIT: begin
          if (ram_ack[tgt_idx]) begin
            ram_req <= '0;
          end
        end
        default: begin
          ram_req <= '0;
        end
      endcase
    end
  end

  // ==========================================================
  // AXI read channel
  logic [7:0] rd_off;
  assign rd_off = 8'(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= IRAP_RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= IRAP_RESP_OKAY;
        s_axi_rdata <= '0;
        case (rd_off)
          IRAP_OFF_TARGET: begin
            s_axi_rdata[IRAP_READY_BIT] <= port_ready_flag_reg;
            s_axi_rdata[IRAP_TARGET_W-1:0] <= target_reg;
          end
          IRAP_OFF_CMD: s_axi_rdata[IRAP_CMD_BIT] <= cmd_reg;
          IRAP_OFF_ADDR: s_axi_rdata[IRAP_WADDR_W-1:0] <= waddr_reg;
          IRAP_OFF_DATA: s_axi_rdata <= data_reg;
          default: s_axi_rresp <= IRAP_RESP_SLVERR;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ==== test/irap_chk.sv ====
// Checker for the indirect RAM access port, bound to irap_top.
// Assumes the clock enable is held high while checked relations run.
`default_nettype none
module irap_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [7:0] ram_req,
  input wire logic ram_we,
  input wire logic [13:0] ram_addr,
  input wire logic [31:0] ram_wdata,
  input wire logic [7:0] ram_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========
  // Assertions
  a_req_onehot: assert property ($onehot0(ram_req))
    else $error("ram request is not one-hot");
  a_req_holds: assert property (ram_req != 0 && (ram_req & ram_ack) == 0 |=>
    $stable(ram_req) && $stable(ram_addr) && $stable(ram_we) && $stable(ram_wdata))
    else $error("ram request changed before ack");
  a_req_release: assert property (clk_en && (ram_req & ram_ack) != 0 |=> ram_req == 0)
    else $error("ram request not released after ack");
  a_launch_cause: assert property ($rose(|ram_req) |-> $past(s_axi_bvalid))
    else $error("ram request without command write");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped or changed");
endmodule
bind irap_top irap_chk irap_chk_inst (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .ram_req(ram_req),
  .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_ack(ram_ack));
`default_nettype wire

// ==== test/irap_ram_model.sv ====
// RAM model behind the access port: one store keyed by target code and word address.
// Assumes one-hot ram_req held until ram_ack; ack delay grows with the target code.
`default_nettype none
module irap_ram_model (
  input wire logic aclk,
  input wire logic [7:0] ram_req,
  input wire logic ram_we,
  input wire logic [13:0] ram_addr,
  input wire logic [31:0] ram_wdata,
  output logic [7:0] ram_ack,
  output logic [31:0] ram_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [int];
  int cnt = 0;
  int t;
  int k;
  // Unwritten words carry target and address, so routing slips show up
  always @(posedge aclk) begin
    ram_ack <= 8'h0;
    ram_rdata <= ~ram_rdata;
    if (ram_req != 0 && ram_ack == 0) begin
      t = $clog2(ram_req);
      k = t * 16384 + int'(ram_addr);
      if (cnt < t) cnt++;
      else begin
        cnt = 0;
        ram_ack <= ram_req;
        if (ram_we) mem[k] = ram_wdata;
        else ram_rdata <= mem.exists(k) ? mem[k] : {4'h0, 4'(t), 10'h0, ram_addr};
      end
    end
  end
  initial ram_ack = 8'h0;
  initial ram_rdata = 32'h0;
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the indirect RAM access port over AXI4-Lite.
// Assumes the RAM model answers every target code with its own delay.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, en = 1;
  logic [7:0] awaddr = 0, araddr = 0, req, ack;
  logic [31:0] wdata = 0, rdata, ram_wd, ram_rd;
  logic [3:0] strb = 4'hf;
  logic [2:0] prot = 3'h0;
  logic awr, wrdy, bv, arr, rv, we;
  logic [1:0] bresp, rresp;
  logic [13:0] ra;
  int n_mismatch = 0, n_tests = 0;
  always #25 aclk = ~aclk;
  irap_top irap_top_inst (.aclk(aclk), .aresetn(aresetn), .clk_en(en),
    .s_axi_awaddr(awaddr), .s_axi_awprot(prot), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(prot), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready), .ram_req(req),
    .ram_we(we), .ram_addr(ra), .ram_wdata(ram_wd), .ram_ack(ack), .ram_rdata(ram_rd));
  irap_ram_model irap_ram_model_inst (.aclk(aclk), .ram_req(req), .ram_we(we),
    .ram_addr(ra), .ram_wdata(ram_wd), .ram_ack(ack), .ram_rdata(ram_rd));
  // ==========
  // Bus tasks
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awr) awv <= 0;
      if (wrdy) wv <= 0;
      if (bv) break;
    end
    bready <= 0;
    if (i == 50) begin
      n_mismatch++;
      complete_run();
    end
    chk(32'(bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int i;
    @(posedge aclk);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arr) arv <= 0;
      if (rv) break;
    end
    rready <= 0;
    if (i == 50) begin
      n_mismatch++;
      complete_run();
    end
    chk(rdata, exp);
    chk(32'(rresp), 32'(er));
  endtask
  // Polls the ready flag through the selector register, bounded
  // Always reads afresh, so a stale ready bit from an earlier read never counts
  task automatic poll;
    int i;
    int j;
    logic done;
    done = 1'b0;
    for (i = 0; i < 40 && !done; i++) begin
      @(posedge aclk);
      araddr <= 8'h24;
      arv <= 1;
      rready <= 1;
      for (j = 0; j < 50; j++) begin
        @(posedge aclk);
        if (arr) arv <= 0;
        if (rv) break;
      end
      rready <= 0;
      done = (j < 50) && (rdata[31] === 1'b1);
    end
    if (!done) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  // ==========
  // Scenarios
  task automatic s_reset;
    rd(8'h24, 32'h8000_0000, 2'b00);
    rd(8'h28, 32'h0, 2'b00);
    rd(8'h2c, 32'h0, 2'b00);
    rd(8'h30, 32'h0, 2'b00);
    rd(8'h34, 32'h0, 2'b10);
    wr(8'h34, 32'h1, 2'b10);
  endtask
  task automatic s_access(input logic [3:0] t, input logic [13:0] a, input logic [31:0] d);
    wr(8'h24, {28'hfffffff, t}, 2'b00);
    wr(8'h2c, {18'h3ffff, a}, 2'b00);
    rd(8'h2c, {18'h0, a}, 2'b00);
    wr(8'h28, 32'h0, 2'b00);
    poll();
    rd(8'h30, {4'h0, t, 10'h0, a}, 2'b00);
    wr(8'h30, d, 2'b00);
    wr(8'h28, 32'h1, 2'b00);
    if (t == 4'h7) rd(8'h24, {28'h0, t}, 2'b00);
    poll();
    wr(8'h30, ~d, 2'b00);
    wr(8'h28, 32'hffff_fffe, 2'b00);
    poll();
    rd(8'h30, d, 2'b00);
    rd(8'h28, 32'h0, 2'b00);
  endtask
  // Reserved codes must finish without touching any RAM
  task automatic s_reserved;
    for (int k = 6; k < 16; k += 9) begin
      wr(8'h30, 32'h5a5a_a5a5, 2'b00);
      wr(8'h24, 32'(k), 2'b00);
      wr(8'h28, 32'h0, 2'b00);
      poll();
      rd(8'h30, 32'h5a5a_a5a5, 2'b00);
    end
  endtask
  // A low clock enable must hold off the answer to a pending read
  task automatic s_freeze;
    int i;
    @(posedge aclk);
    en <= 0;
    araddr <= 8'h24;
    arv <= 1;
    rready <= 1;
    repeat (6) @(posedge aclk);
    chk({30'h0, rv, arr}, 32'h0);
    en <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arr) arv <= 0;
      if (rv) break;
    end
    rready <= 0;
    if (i == 50) begin
      n_mismatch++;
      complete_run();
    end
    chk(rdata, 32'h8000_000f);
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    s_reset();
    for (int t = 0; t < 8; t++)
      if (t != 6) s_access(4'(t), (t == 7) ? 14'h3fff : 14'(t * 1000), {4'(t), 28'h1234567});
    s_reserved();
    s_freeze();
    complete_run();
  end
endmodule
`default_nettype wire
